/* hw/io_serdes_clocking.sv */
// Pin serdes slice clocking with its nibble controller and AXI4-Lite port
`timescale 1ns/1ps
module io_serdes_clocking
   import io_serdes_pkg::*;
#(
   parameter logic SERIAL_MODE_DEFAULT = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [1:0] rx_pin,
   input wire logic strobe_pin,
   input wire logic nibble_pos_in,
   input wire logic nibble_neg_in,
   input wire logic pll_clk_ok,
   input wire logic gen_clk_ok,
   output logic tx_pin,
   output logic fifo_write_clk_copy,
   output logic fwd_clk_north,
   output logic fwd_clk_south,
   output logic nibble_pos_out,
   output logic nibble_neg_out,
   output logic input_delay_track_en,
   output logic output_delay_track_en,
   output logic third_delay_track_en
);
   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // Word address match; an unaligned address is unmapped
   function automatic logic reg_at(input logic [AW-1:0] a,
      input logic [AW-1:0] ofs);
      return a == ofs;
   endfunction : reg_at

   // Right-align a word shifted in from the top
   function automatic logic [7:0] align(input logic [7:0] v,
      input logic w8);
      return w8 ? v : {4'h0, v[7:4]};
   endfunction : align

   ctrl_t ctrl_r, ctrl_nxt;
   pins_t s1_r, s2_r;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt, aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt, wd_r, wd_nxt;
   logic [AW-1:0] awa_r, awa_nxt;
   logic [3:0] ws_r, ws_nxt;
   logic tx_load, pop_req, ovf_clr;
   logic sp_d1_r, sp_d2_r, sn_d1_r, sn_d2_r;
   logic [7:0] acc_r, acc_nxt, img_r, img_nxt;
   logic [3:0] cnt_r, cnt_nxt, width, tx_cnt_r, tx_cnt_nxt;
   rx_word_t fifo_mem [4];
   rx_word_t word, head;
   logic [PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PTR_W:0] fill_r, fill_nxt;
   logic ovf_r, ovf_nxt, wclk_r, wclk_nxt, mclk_r, mclk_nxt;
   logic fwdn_r, fwdn_nxt, fwds_r, fwds_nxt, npo_r, npo_nxt;
   logic nno_r, nno_nxt;
   logic [6:0] lanes_r, lanes_nxt;
   logic sp, sn, rise, fall, master_ok, ser, push, push_ok, pop_ok;
   logic [1:0] v, b, ib;
   stat_t stat, stat_wr;
   logic [31:0] wr_ctrl, wr_word;
   tx_st_t tx_st_r, tx_st_nxt;
   logic [7:0] tx_word_r, tx_word_nxt;
   logic tx_bit_r, tx_bit_nxt, tx_dly_r, tx_pin_r, tx_pin_nxt;
   logic [2:0] ser8_cnt_r, ser8_cnt_nxt;

   // Outputs straight from flops
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign tx_pin = tx_pin_r;
   assign fifo_write_clk_copy = wclk_r;
   assign fwd_clk_north = fwdn_r;
   assign fwd_clk_south = fwds_r;
   assign nibble_pos_out = npo_r;
   assign nibble_neg_out = nno_r;
   assign input_delay_track_en = ctrl_r.trk_in;
   assign output_delay_track_en = ctrl_r.trk_out;
   assign third_delay_track_en = ctrl_r.trk_third;

   // Status word and FIFO head
   assign head = fifo_mem[rp_r];
   assign stat = '{fill: fill_r, lanes: lanes_r, overflow: ovf_r,
      master_ok: master_ok, full: fill_r == FIFO_DEPTH,
      empty: fill_r == '0};

   // Bus slave: write and read channels, register decode
   always_comb begin
      wr_ctrl = merge({15'h0, ctrl_r}, wd_r, ws_r);
      wr_word = merge(32'h0, wd_r, ws_r);
      stat_wr = stat_t'(wr_word[$bits(stat_t)-1:0]);
      ctrl_nxt = ctrl_r;
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      tx_load = 1'b0;
      pop_req = 1'b0;
      ovf_clr = 1'b0;
      if (awvalid && awready_r) begin
         awa_nxt = awaddr;
         aw_got_nxt = 1'b1;
         awready_nxt = 1'b0;
      end
      if (wvalid && wready_r) begin
         wd_nxt = wdata;
         ws_nxt = wstrb;
         w_got_nxt = 1'b1;
         wready_nxt = 1'b0;
      end
      if (aw_got_r && w_got_r && !bvalid_r) begin
         bvalid_nxt = 1'b1;
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bresp_nxt = RESP_OK;
         if (reg_at(awa_r, CTRL_OFS)) begin
            ctrl_nxt = ctrl_t'(wr_ctrl[$bits(ctrl_t)-1:0]);
         end else if (reg_at(awa_r, TXD_OFS)) begin
            tx_load = (tx_st_r == TX_IDLE) && ws_r[0];
         end else if (reg_at(awa_r, STAT_OFS)) begin
            ovf_clr = stat_wr.overflow;
         end else if (!reg_at(awa_r, RXD_OFS)) begin
            bresp_nxt = RESP_SLVERR;
         end
      end
      if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
         awready_nxt = 1'b1;
         wready_nxt = 1'b1;
      end
      if (arvalid && arready_r) begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OK;
         rdata_nxt = 32'h0;
         if (reg_at(araddr, CTRL_OFS)) begin
            rdata_nxt = {15'h0, ctrl_r};
         end else if (reg_at(araddr, TXD_OFS)) begin
            rdata_nxt = {23'h0, tx_st_r == TX_SHIFT, tx_word_r};
         end else if (reg_at(araddr, RXD_OFS)) begin
            rdata_nxt = {15'h0, !stat.empty, head};
            pop_req = 1'b1;
         end else if (reg_at(araddr, STAT_OFS)) begin
            rdata_nxt = {18'h0, stat};
         end else begin
            rresp_nxt = RESP_SLVERR;
         end
      end
      if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   // Bus and control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= ctrl_t'(CTRL_RST | {16'h0, SERIAL_MODE_DEFAULT});
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OK;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OK;
         rdata_r <= 32'h0;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awa_r <= '0;
         wd_r <= 32'h0;
         ws_r <= 4'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
      end
   end

   // Two-stage synchroniser for every pin input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= '{gen_ok: gen_clk_ok, pll_ok: pll_clk_ok,
            nib_neg: nibble_neg_in, nib_pos: nibble_pos_in,
            strobe: strobe_pin, rx: rx_pin};
         s2_r <= s1_r;
      end
   end

   // Capture clocking, deserialiser, FIFO and clock forwarding
   always_comb begin
      master_ok = ctrl_r.master_clk_select ? s2_r.gen_ok
         : s2_r.pll_ok;
      ser = ctrl_r.serial_mode || ctrl_r.data_type == DT_SERIAL;
      sp = (ctrl_r.nibble_share_pos_dir ? s2_r.nib_pos : s2_r.strobe)
         ^ ctrl_r.rx_clk_invert;
      sn = (ctrl_r.nibble_share_neg_dir ? s2_r.nib_neg : s2_r.strobe)
         ^ ctrl_r.rx_clk_invert;
      // Shifted capture samples the strobe edge one step later
      rise = ctrl_r.rx_phase_p90 ? (sp_d1_r & ~sp_d2_r)
         : (sp & ~sp_d1_r);
      fall = ctrl_r.rx_phase_n90 ? (~sn_d1_r & sn_d2_r)
         : (~sn & sn_d1_r);
      width = ctrl_r.width8 ? W8 : W4;
      if (ser) begin
         v = {2{master_ok}};
         b = s2_r.rx;
         ib = 2'h0;
      end else begin
         v = {fall, rise};
         b = {2{s2_r.rx[0]}};
         ib = 2'h1;
      end
      acc_nxt = acc_r;
      img_nxt = img_r;
      cnt_nxt = cnt_r;
      push = 1'b0;
      word = '0;
      for (int i = 0; i < 2; i++) begin
         if (v[i]) begin
            acc_nxt = {b[i], acc_nxt[7:1]};
            img_nxt = {ib[i], img_nxt[7:1]};
            cnt_nxt = cnt_nxt + 4'h1;
            if (cnt_nxt == width) begin
               push = 1'b1;
               cnt_nxt = 4'h0;
               word.data = align(acc_nxt, ctrl_r.width8);
               word.img = (ctrl_r.data_type == DT_DATA_CLK)
                  ? align(img_nxt, ctrl_r.width8) : 8'h0;
            end
         end
      end
      wclk_nxt = cnt_nxt >= (width >> 1);
      mclk_nxt = master_ok ? ~mclk_r : mclk_r;
      fwdn_nxt = ctrl_r.fwd_clk_north_en & (ser ? mclk_r : sp);
      fwds_nxt = ctrl_r.fwd_clk_south_en & (ser ? mclk_r : sp);
      npo_nxt = ~ctrl_r.nibble_share_pos_dir & s2_r.strobe;
      nno_nxt = ~ctrl_r.nibble_share_neg_dir & s2_r.strobe;
      lanes_nxt = !ser ? LANES_STROBE
         : ctrl_r.diff_in ? LANES_DIFF : LANES_ALL;
      push_ok = push && !stat.full;
      pop_ok = pop_req && !stat.empty;
      ovf_nxt = (push && stat.full) || (ovf_r && !ovf_clr);
      fill_nxt = fill_r + {2'h0, push_ok} - {2'h0, pop_ok};
      wp_nxt = wp_r + {1'b0, push_ok};
      rp_nxt = rp_r + {1'b0, pop_ok};
      ser8_cnt_nxt = !(ser && ctrl_r.width8 && master_ok) ? 3'h0
         : (ser8_cnt_r == 3'h7) ? ser8_cnt_r : ser8_cnt_r + 3'h1;
   end

   // Capture registers and FIFO storage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {sp_d1_r, sp_d2_r, sn_d1_r, sn_d2_r} <= 4'h0;
         acc_r <= 8'h0;
         img_r <= 8'h0;
         cnt_r <= 4'h0;
         {wclk_r, mclk_r, fwdn_r, fwds_r, npo_r, nno_r} <= 6'h0;
         lanes_r <= LANES_ALL;
         ovf_r <= 1'b0;
         fill_r <= '0;
         wp_r <= '0;
         rp_r <= '0;
         ser8_cnt_r <= 3'h0;
      end else begin
         {sp_d1_r, sp_d2_r, sn_d1_r, sn_d2_r} <= {sp, sp_d1_r, sn, sn_d1_r};
         acc_r <= acc_nxt;
         img_r <= img_nxt;
         cnt_r <= cnt_nxt;
         {wclk_r, mclk_r, fwdn_r, fwds_r, npo_r, nno_r} <=
            {wclk_nxt, mclk_nxt, fwdn_nxt, fwds_nxt, npo_nxt, nno_nxt};
         lanes_r <= lanes_nxt;
         ovf_r <= ovf_nxt;
         fill_r <= fill_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         ser8_cnt_r <= ser8_cnt_nxt;
         if (push_ok) begin
            fifo_mem[wp_r] <= word;
         end
      end
   end

   // Transmit shifter on the master clock, LSB first
   always_comb begin
      tx_st_nxt = tx_st_r;
      tx_word_nxt = tx_word_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_bit_nxt = tx_bit_r;
      case (tx_st_r)
         TX_IDLE: begin
            if (tx_load) begin
               tx_word_nxt = wr_word[7:0];
               tx_cnt_nxt = 4'h0;
               tx_st_nxt = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (master_ok) begin
               tx_bit_nxt = tx_word_r[0];
               tx_word_nxt = {1'b0, tx_word_r[7:1]};
               tx_cnt_nxt = tx_cnt_r + 4'h1;
               if (tx_cnt_nxt == width) begin
                  tx_st_nxt = TX_IDLE;
               end
            end
         end
      endcase
      tx_pin_nxt = ctrl_r.tx_shift90 ? tx_dly_r : tx_bit_r;
   end

   // Transmit registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_st_r <= TX_IDLE;
         tx_word_r <= 8'h0;
         tx_cnt_r <= 4'h0;
         {tx_bit_r, tx_dly_r, tx_pin_r} <= 3'h0;
      end else begin
         tx_st_r <= tx_st_nxt;
         tx_word_r <= tx_word_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         {tx_bit_r, tx_dly_r, tx_pin_r} <= {tx_bit_nxt, tx_bit_r, tx_pin_nxt};
      end
   end

   // Checks on the clocking behaviour
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_track_reset_on: assert property (
      $past(!aresetn) |-> {ctrl_r.trk_in, ctrl_r.trk_out,
         ctrl_r.trk_third} == 3'h7) else $error("tracking not on");
   a_fwd_north_gate: assert property (
      !$past(ctrl_r.fwd_clk_north_en) |-> !fwd_clk_north)
      else $error("north clock leaked");
   a_fwd_south_gate: assert property (
      !$past(ctrl_r.fwd_clk_south_en) |-> !fwd_clk_south)
      else $error("south clock leaked");
   a_share_pos_dir: assert property (
      $past(ctrl_r.nibble_share_pos_dir) |-> !nibble_pos_out)
      else $error("nibble clock driven inward");
   a_tx_shift_delay: assert property (
      ctrl_r.tx_shift90 && $past(ctrl_r.tx_shift90)
      |-> tx_pin == $past(tx_bit_r, 2)) else $error("tx shift wrong");
   // Master clock kept running through a whole word time
   sequence s_steady;
      (ser8_cnt_r == 3'h7) [*4];
   endsequence
   a_serial_quarter_rate: assert property (
      (push && ser8_cnt_r == 3'h7) ##1 s_steady ##0 master_ok
      |-> push && !$past(push) && !$past(push, 2) && !$past(push, 3))
      else $error("serial word rate wrong");
   a_wclk_divide: assert property (
      (ser8_cnt_r == 3'h7 && $rose(wclk_r) && $past(ser8_cnt_r) == 3'h7)
      |-> $past(wclk_r, 4) && !$past(wclk_r, 5))
      else $error("write clock copy period wrong");
   a_diff_lanes: assert property (
      $past(ser && ctrl_r.diff_in) |-> lanes_r == LANES_DIFF)
      else $error("differential lane six usable");
   a_fifo_count: assert property (
      fill_r == $past(fill_r) + {2'h0, $past(push_ok)}
      - {2'h0, $past(pop_ok)} && fill_r <= FIFO_DEPTH)
      else $error("fifo fill count wrong");
   a_tx_master_hold: assert property (
      (tx_st_r == TX_SHIFT && !master_ok) |=> tx_cnt_r == $past(tx_cnt_r))
      else $error("tx shifted without master clock");
endmodule : io_serdes_clocking

/* hw/io_serdes_pkg.sv */
// Shared constants and types for the pin serdes clocking block
package io_serdes_pkg;
   // Register map, byte addresses
   localparam int AW = 4;
   localparam logic [AW-1:0] CTRL_OFS = 4'h0;
   localparam logic [AW-1:0] TXD_OFS = 4'h4;
   localparam logic [AW-1:0] RXD_OFS = 4'h8;
   localparam logic [AW-1:0] STAT_OFS = 4'hc;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Converter widths; division is width / 2
   localparam logic [3:0] W8 = 4'h8;
   localparam logic [3:0] W4 = 4'h4;
   // Receive FIFO
   localparam int PTR_W = 2;
   localparam logic [PTR_W:0] FIFO_DEPTH = 3'h4;
   // Usable data lanes of a nibble
   localparam logic [6:0] LANES_ALL = 7'h7f;
   localparam logic [6:0] LANES_DIFF = 7'h3f;
   localparam logic [6:0] LANES_STROBE = 7'h7e;
   // Receive data type
   typedef enum logic [1:0] {
      DT_DATA = 2'h0,
      DT_DATA_CLK = 2'h1,
      DT_SERIAL = 2'h2
   } dtype_t;
   // Transmit sequencer
   typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_st_t;
   // Control register layout
   typedef struct packed {
      logic trk_in;
      logic trk_out;
      logic trk_third;
      logic diff_in;
      logic master_clk_select;
      logic nibble_share_neg_dir;
      logic nibble_share_pos_dir;
      logic fwd_clk_south_en;
      logic fwd_clk_north_en;
      logic tx_shift90;
      logic rx_phase_n90;
      logic rx_phase_p90;
      logic rx_clk_invert;
      logic width8;
      dtype_t data_type;
      logic serial_mode;
   } ctrl_t;
   localparam logic [16:0] CTRL_RST = 17'h1c008;
   // Status register layout
   typedef struct packed {
      logic [PTR_W:0] fill;
      logic [6:0] lanes;
      logic overflow;
      logic master_ok;
      logic full;
      logic empty;
   } stat_t;
   // Synchronised pin group
   typedef struct packed {
      logic gen_ok;
      logic pll_ok;
      logic nib_neg;
      logic nib_pos;
      logic strobe;
      logic [1:0] rx;
   } pins_t;
   // One receive FIFO entry
   typedef struct packed {
      logic [7:0] img;
      logic [7:0] data;
   } rx_word_t;
endpackage : io_serdes_pkg

/* verif/io_serdes_clocking_bench.sv */
// Self-checking bench for the pin serdes clocking block
`timescale 1ns/1ps
module io_serdes_clocking_bench;
   import io_serdes_pkg::*;
   localparam logic [31:0] CBASE = 32'h0001c009;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, strobe_pin, pll_clk_ok;
   logic gen_clk_ok, tx_pin, peer_en, wclk, fwd_n, fwd_s, nib_p, nib_n;
   logic trk_i, trk_o, trk_t;
   logic [AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rx_pin, resp;
   logic [23:0] tx_log;
   int failures = 0;
   int n_tests = 0;
   int k0, k1;

   io_serdes_clocking i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_pin,
      .strobe_pin, .nibble_pos_in(1'b0), .nibble_neg_in(1'b0), .pll_clk_ok,
      .gen_clk_ok, .tx_pin, .fifo_write_clk_copy(wclk), .fwd_clk_north(fwd_n),
      .fwd_clk_south(fwd_s), .nibble_pos_out(nib_p), .nibble_neg_out(nib_n),
      .input_delay_track_en(trk_i), .output_delay_track_en(trk_o),
      .third_delay_track_en(trk_t));
   serial_peer i_peer (.aclk, .en(peer_en), .tx_pin, .rx_pin, .strobe_pin,
      .tx_log);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic tally_and_finish;
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Write cycle: address and data offered together, each dropped when taken
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 200);
      bready <= 1'b0;
      resp = bresp;
      if (n >= 200) failures++;
   endtask : wr

   task automatic rdr(input logic [AW-1:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      rready <= 1'b0;
      rd = rdata;
      resp = rresp;
      if (n >= 200) failures++;
   endtask : rdr

   // Cycles between two rising edges of the write clock copy
   task automatic wclk_period(input int exp);
      int n, m;
      n = 0;
      m = 0;
      for (int i = 0; i < 2; i++) begin
         m = n;
         while (wclk !== 1'b0 && n < 60) begin
            @(posedge aclk);
            n++;
         end
         while (wclk !== 1'b1 && n < 60) begin
            @(posedge aclk);
            n++;
         end
      end
      check(n - m, exp);
   endtask : wclk_period

   task automatic t_reset_map;
      rdr(CTRL_OFS);
      check(rd, CBASE);
      check({trk_i, trk_o, trk_t}, 3'h7);
      rdr(STAT_OFS);
      check(rd, 32'h7f1);
      wr(4'h2, 32'h0);
      check(resp, RESP_SLVERR);
      rdr(4'h2);
      check(resp, RESP_SLVERR);
      wr(CTRL_OFS, 32'h4009);
      check({trk_i, trk_o, trk_t}, 3'h1);
      wr(CTRL_OFS, 32'h18009);
      check({trk_i, trk_o, trk_t}, 3'h6);
      rdr(CTRL_OFS);
      check(rd, 32'h18009);
   endtask : t_reset_map

   // Usable lanes per capture mode
   task automatic t_lanes;
      logic [31:0] cv [4];
      logic [6:0] lv [4];
      cv = '{CBASE | 32'h2000, 32'h1c00a, 32'h1c00c, CBASE};
      lv = '{LANES_DIFF, LANES_STROBE, LANES_ALL, LANES_ALL};
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_OFS, cv[i]);
         rdr(STAT_OFS);
         check(rd[10:4], lv[i]);
      end
   endtask : t_lanes

   task automatic t_serial;
      peer_en <= 1'b1;
      repeat (4) @(posedge aclk);
      pll_clk_ok <= 1'b1; // Master runs at the set frequency
      wclk_period(4);
      repeat (60) @(posedge aclk);
      rdr(STAT_OFS);
      check(rd, 32'h27fe);
      pll_clk_ok <= 1'b0;
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
         rdr(RXD_OFS);
         check(rd & 32'h100ff, 32'h10055);
      end
      rdr(RXD_OFS);
      check(rd[16], 1'b0);
      rdr(STAT_OFS);
      check(rd, 32'h7f9);
      wr(STAT_OFS, 32'h8);
      rdr(STAT_OFS);
      check(rd, 32'h7f1);
      wr(CTRL_OFS, 32'h1c001); // Width 4 pairs with division 2
      pll_clk_ok <= 1'b1;
      wclk_period(2);
      wr(CTRL_OFS, CBASE | 32'h1000);
      repeat (4) @(posedge aclk);
      rdr(STAT_OFS);
      check(rd[2], 1'b0);
      gen_clk_ok <= 1'b1;
      repeat (4) @(posedge aclk);
      rdr(STAT_OFS);
      check(rd[2], 1'b1);
   endtask : t_serial

   // Forwarded and shared clocks follow their enables
   task automatic t_fwd;
      int hn, hs;
      for (int i = 0; i < 3; i++) begin
         wr(CTRL_OFS, CBASE | (i == 2 ? 32'hc00 : 32'h100 << i));
         hn = 0;
         hs = 0;
         repeat (16) begin
            @(posedge aclk);
            hn += (i == 2) ? int'(nib_p === 1'b1) : int'(fwd_n === 1'b1);
            hs += (i == 2) ? int'(nib_n === 1'b1) : int'(fwd_s === 1'b1);
         end
         check({hn != 0, hs != 0}, i == 0 ? 2'h2 : i == 1 ? 2'h1 : 2'h0);
      end
   endtask : t_fwd

   function automatic int find_k(input logic [23:0] lg);
      for (int k = 0; k < 16; k++) begin
         if ({lg[23-k-7], lg[23-k-6], lg[23-k-5], lg[23-k-4], lg[23-k-3],
              lg[23-k-2], lg[23-k-1], lg[23-k]} === 8'ha5) return k;
      end
      return 16;
   endfunction : find_k

   task automatic t_tx;
      for (int i = 0; i < 2; i++) begin
         wr(CTRL_OFS, CBASE | (i == 1 ? 32'h80 : 32'h0));
         wr(TXD_OFS, 32'ha5);
         repeat (20) @(posedge aclk);
         if (i == 0) k0 = find_k(tx_log);
         else k1 = find_k(tx_log);
      end
      check(k0 < 16, 1'b1);
      check(k1, k0 + 1);
   endtask : t_tx

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {pll_clk_ok, gen_clk_ok, peer_en} = 3'h0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_map();
      t_lanes();
      t_serial();
      t_fwd();
      t_tx();
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      tally_and_finish();
   end
endmodule : io_serdes_clocking_bench

/* verif/serial_peer.sv */
// Behavioural serial data source and transmit sink facing the slice
`timescale 1ns/1ps
module serial_peer (
   input wire logic aclk,
   input wire logic en,
   input wire logic tx_pin,
   output logic [1:0] rx_pin,
   output logic strobe_pin,
   output logic [23:0] tx_log
);
   initial begin
      rx_pin = 2'h2;
      strobe_pin = 1'b0;
      tx_log = 24'h0;
   end
   // One bit per master edge, rising sample on [0]; a released line toggles
   always @(posedge aclk) begin
      rx_pin <= en ? 2'h1 : ~rx_pin;
      tx_log <= {tx_log[22:0], tx_pin}; // Oldest bit at the top
   end
endmodule : serial_peer
